// file: rtl/rx_event_counters.sv
// receive event counter bank: slips, frame loss, alignment changes, link 1 checksum errors
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Summary of operation
// - 8-bit counter of receive slip events
// - slip counts frame repeats and drops
// - counters reset zero, count, clear on read
// - 8-bit counter of loss-of-frame conditions
// - count loss-of-frame once per new declaration
// - 8-bit counter of alignment change events
// - alignment change when a valid lock differs from offline
// - 8-bit counter of link 1 checksum errors
// - only link controller one advances it
// ---------------------------------------------------------------------------
module rx_event_counters #(
    parameter logic [3:0] CHANNEL = rx_event_counters_pkg::CHANNEL_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_n,
    input rx_event_counters_pkg::reg_req_t req,
    output logic [rx_event_counters_pkg::DATA_W-1:0] rdata,
    input rx_event_counters_pkg::framer_events_t ev,
    output logic irq
);
    import rx_event_counters_pkg::*;

    // ---------------------------------------------------------------------------
    // derived widths and the counter map
    // ---------------------------------------------------------------------------
    localparam int CHAN_W = $bits(CHANNEL);
    localparam int OFF_W = $bits(OFF_SLIP);

    // counter offsets by event position, so one loop serves the whole bank
    localparam logic [OFF_W-1:0] CNT_OFF [NUM_CNT] = '{
        EV_SLIP: OFF_SLIP,
        EV_FRAME_LOSS: OFF_FRAME_LOSS,
        EV_ALIGN_CHANGE: OFF_ALIGN_CHANGE,
        EV_LINK1_FCS: OFF_LINK1_FCS
    };

    // ---------------------------------------------------------------------------
    // elaboration checks
    // ---------------------------------------------------------------------------
    // register map and status layout are fixed at four byte-wide counters
    if (DATA_W != 8 || NUM_CNT != 4) begin : g_bad_shape
        $error("rx_event_counters: bank is built for four 8-bit counters");
    end

    // status and mask each take their own byte with zero padding above them
    if (DATA_W < NUM_CNT) begin : g_bad_status
        $error("rx_event_counters: status does not fit the data width");
    end

    // channel nibble and offset must split the address exactly
    if (CHAN_W + OFF_W != ADDR_W) begin : g_bad_addr
        $error("rx_event_counters: channel and offset do not fill the address");
    end

    // every event needs its own bit in status, mask and counter array
    if (EV_SLIP >= NUM_CNT || EV_FRAME_LOSS >= NUM_CNT
        || EV_ALIGN_CHANGE >= NUM_CNT || EV_LINK1_FCS >= NUM_CNT) begin : g_bad_index
        $error("rx_event_counters: event index outside the bank");
    end

    // ---------------------------------------------------------------------------
    // state
    // ---------------------------------------------------------------------------
    typedef struct packed {
        logic frame_loss_d;
        logic [NUM_CNT-1:0] status;
        logic [NUM_CNT-1:0] mask;
        logic [DATA_W-1:0] rdata;
    } bank_state_t;

    bank_state_t state_reg;
    bank_state_t state_next;

    logic chan_hit;
    logic [OFF_W-1:0] off;
    logic rd_hit;
    logic wr_hit;
    logic sel_status;
    logic sel_mask;
    logic [NUM_CNT-1:0] sel_cnt;
    logic [NUM_CNT-1:0] event_pulse;
    logic [NUM_CNT-1:0] clear_hit;
    logic [NUM_CNT-1:0] status_clr;
    logic [NUM_CNT-1:0] status_set;
    logic [DATA_W-1:0] count [NUM_CNT];
    logic [DATA_W-1:0] cnt_word [NUM_CNT];
    logic [DATA_W-1:0] cnt_rdata;
    logic [DATA_W-1:0] reg_rdata;
    logic [DATA_W-1:0] rdata_mux;

    // ---------------------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------------------
    assign chan_hit = req.addr[ADDR_W-1 -: CHAN_W] == CHANNEL;
    assign off = req.addr[OFF_W-1:0];
    // other-channel traffic stops here, so nothing below can see it
    assign rd_hit = req.rd && chan_hit;
    assign wr_hit = req.wr && chan_hit;
    assign sel_status = off == OFF_EVENT_STATUS;
    assign sel_mask = off == OFF_EVENT_MASK;

    // ---------------------------------------------------------------------------
    // event detection
    // ---------------------------------------------------------------------------
    always_comb begin
        event_pulse = '0;
        event_pulse[EV_SLIP] = ev.slip_repeat | ev.slip_drop;
        // rising edge only, so a long outage counts once
        event_pulse[EV_FRAME_LOSS] = ev.frame_loss & ~state_reg.frame_loss_d;
        event_pulse[EV_ALIGN_CHANGE] = ev.locked_valid && (ev.locked_pos != ev.offline_pos);
        // links 2 and 3 are deliberately ignored
        event_pulse[EV_LINK1_FCS] = ev.fcs_err_link1;
    end

    // ---------------------------------------------------------------------------
    // counters
    // ---------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
            if (CNT_OFF[gi] == OFF_EVENT_STATUS || CNT_OFF[gi] == OFF_EVENT_MASK) begin : g_bad_off
                $error("rx_event_counters: counter offset collides with status or mask");
            end

            assign sel_cnt[gi] = off == CNT_OFF[gi];
            // only a read clears; a write to a counter offset is ignored
            assign clear_hit[gi] = rd_hit && sel_cnt[gi];

            sat_event_counter #(
                .WIDTH(DATA_W)
            ) u_cnt (
                .clk(clk),
                .rst_n(rst_n),
                .event_pulse(event_pulse[gi]),
                .clear_on_read(clear_hit[gi]),
                .count(count[gi])
            );

            // and-or read leg, zero unless this counter is addressed
            assign cnt_word[gi] = sel_cnt[gi] ? count[gi] : ZERO_BYTE;
        end
    endgenerate

    always_comb begin
        cnt_rdata = ZERO_BYTE;
        for (int i = 0; i < NUM_CNT; i++) begin
            cnt_rdata = cnt_rdata | cnt_word[i];
        end
    end

    // ---------------------------------------------------------------------------
    // event status, write one to clear
    // ---------------------------------------------------------------------------
    generate
        for (gi = 0; gi < NUM_CNT; gi++) begin : g_status
            assign status_clr[gi] = wr_hit && sel_status && req.wdata[gi];
            // a new event wins over a clear in the same cycle
            assign status_set[gi] = event_pulse[gi];
        end
    endgenerate

    // ---------------------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------------------
    always_comb begin
        reg_rdata = ZERO_BYTE;
        if (sel_status) begin
            reg_rdata = DATA_W'(state_reg.status);
        end else if (sel_mask) begin
            reg_rdata = DATA_W'(state_reg.mask);
        end
    end

    // unmapped or other-channel reads answer zero
    assign rdata_mux = rd_hit ? (cnt_rdata | reg_rdata) : ZERO_BYTE;

    // ---------------------------------------------------------------------------
    // registers and interrupt state
    // ---------------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.frame_loss_d = ev.frame_loss;
        state_next.status = (state_reg.status & ~status_clr) | status_set;
        if (wr_hit && sel_mask) begin
            state_next.mask = req.wdata[NUM_CNT-1:0];
        end
        state_next.rdata = rdata_mux;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg.frame_loss_d <= 1'b0;
            state_reg.status <= STATUS_RESET;
            state_reg.mask <= MASK_RESET;
            state_reg.rdata <= ZERO_BYTE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata = state_reg.rdata;
    assign irq = |(state_reg.status & state_reg.mask);
endmodule

// file: rtl/rx_event_counters_pkg.sv
// package: register map, field widths and shared types of the receive event counter bank
package rx_event_counters_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int NUM_CNT = 4;

    // printed offsets carry the channel nibble in bits 15:12
    localparam logic [11:0] OFF_SLIP = 12'h909;
    localparam logic [11:0] OFF_FRAME_LOSS = 12'h90a;
    localparam logic [11:0] OFF_ALIGN_CHANGE = 12'h90b;
    localparam logic [11:0] OFF_LINK1_FCS = 12'h90c;
    localparam logic [11:0] OFF_EVENT_STATUS = 12'h920;
    localparam logic [11:0] OFF_EVENT_MASK = 12'h921;
    localparam logic [3:0] CHANNEL_DEFAULT = 4'h0;

    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [3:0] STATUS_RESET = 4'h0;
    localparam logic [3:0] MASK_RESET = 4'h0;

    // event bit positions, shared by counters, status and mask
    localparam int EV_SLIP = 0;
    localparam int EV_FRAME_LOSS = 1;
    localparam int EV_ALIGN_CHANGE = 2;
    localparam int EV_LINK1_FCS = 3;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic slip_repeat;
        logic slip_drop;
        logic frame_loss;
        logic locked_valid;
        logic [7:0] locked_pos;
        logic [7:0] offline_pos;
        logic fcs_err_link1;
        logic fcs_err_link2;
        logic fcs_err_link3;
    } framer_events_t;
endpackage

// file: rtl/sat_event_counter.sv
// single saturating event counter that clears when read
`timescale 1ns/1ps
module sat_event_counter #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic event_pulse,
    input wire logic clear_on_read,
    output logic [WIDTH-1:0] count
);
    import rx_event_counters_pkg::*;

    // refused at elaboration, before any logic is built
    if (WIDTH < 1) begin : g_bad_width
        $error("sat_event_counter: WIDTH must be at least 1");
    end

    typedef struct packed {
        logic [WIDTH-1:0] count;
    } cnt_state_t;

    cnt_state_t state_reg;
    cnt_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (clear_on_read) begin
            // event landing with the read starts the new interval at one
            state_next.count = event_pulse ? WIDTH'(1) : '0;
        end else if (event_pulse && state_reg.count != '1) begin
            state_next.count = state_reg.count + WIDTH'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign count = state_reg.count;
endmodule

// file: test/rx_event_counters_props.sv
// checker: read-clear counter properties of the event counter bank
`timescale 1ns/1ps
module rx_event_counters_props (
    input wire logic clk,
    input wire logic rst_n,
    input rx_event_counters_pkg::reg_req_t req,
    input logic [rx_event_counters_pkg::DATA_W-1:0] rdata,
    input rx_event_counters_pkg::framer_events_t ev,
    input logic irq
);
    import rx_event_counters_pkg::*;
    logic rs, rf, ra, rl, es, alignment_change_event;
    assign rs = req.rd && req.addr == {4'h0, OFF_SLIP};
    assign rf = req.rd && req.addr == {4'h0, OFF_FRAME_LOSS};
    assign ra = req.rd && req.addr == {4'h0, OFF_ALIGN_CHANGE};
    assign rl = req.rd && req.addr == {4'h0, OFF_LINK1_FCS};
    assign es = ev.slip_repeat | ev.slip_drop;
    assign alignment_change_event = ev.locked_valid && ev.locked_pos != ev.offline_pos;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----
    // properties
    // ----
    a_rdata_idle: assert property (!req.rd |=> rdata == 8'h00) else $error("rdata not idle");
    a_read_clears: assert property ((rs && !es) ##1 (rs && !es) |=> rdata == 8'h00)
        else $error("read did not clear");
    a_slip_repeat: assert property ((rs && !es) ##1 (ev.slip_repeat && !ev.slip_drop && !req.rd)
        ##1 (rs && !es) |=> rdata == 8'h01) else $error("repeat slip miscounted");
    a_slip_drop: assert property ((rs && !es) ##1 (ev.slip_drop && !ev.slip_repeat && !req.rd)
        ##1 (rs && !es) |=> rdata == 8'h01) else $error("drop slip miscounted");
    a_same_edge: assert property ((rs && es) ##1 (rs && !es) |=> rdata == 8'h01)
        else $error("event at read lost");
    a_loss_once: assert property ((ev.frame_loss && !req.rd) ##1 (rf && ev.frame_loss)
        ##1 (rf && ev.frame_loss) |=> rdata == 8'h00) else $error("held loss counted again");
    a_loss_rise: assert property ((rf && !ev.frame_loss) ##1 (ev.frame_loss && !req.rd)
        ##1 rf |=> rdata == 8'h01) else $error("loss rise miscounted");
    a_align_diff: assert property ((ra && !ev.locked_valid) ##1 (ev.locked_valid && !req.rd)
        ##1 (ra && !ev.locked_valid) |=> rdata == {7'h0, $past(alignment_change_event, 2)})
        else $error("alignment miscounted");
    a_link_only: assert property ((rl && !ev.fcs_err_link1) ##1 !req.rd ##1 (rl && !ev.fcs_err_link1)
        |=> rdata == {7'h0, $past(ev.fcs_err_link1, 2)}) else $error("checksum miscounted");
    c_same_edge: cover property (rs && es);
    c_align_change: cover property (ra && alignment_change_event);
    c_irq: cover property (irq);
endmodule

// file: test/rx_event_counters_tb.sv
// bench: random traffic against a behavioural model of the counter bank
`timescale 1ns/1ps
module t1_rx_event_counters_tb;
    import rx_event_counters_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic irq;
    logic [7:0] rdata;
    reg_req_t req = '0;
    framer_events_t ev = '0;
    int err_total = 0, checks_done = 0, cyc = 0, cnt[4] = '{0, 0, 0, 0}, st = 0, mk = 0, exp_rd = 0, fl_old = 0;
    // last two: unmapped and wrong channel
    logic [15:0] ad[8] = '{16'h0909, 16'h090a, 16'h090b, 16'h090c, 16'h0920, 16'h0921, 16'h0930, 16'h1909};
    rx_event_counters DUT (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .ev(ev), .irq(irq));
    initial forever #12.5 clk = ~clk;
    task chk_rdata(input logic [7:0] got, input logic [7:0] e);
        checks_done++;
        if (got !== e) begin
            err_total++;
            $display("mismatch t=%0t rdata got %h exp %h", $time, got, e);
        end
    endtask
    task chk_irq(input logic got, input bit e);
        checks_done++;
        if (got !== e) begin
            err_total++;
            $display("mismatch t=%0t irq got %b exp %b", $time, got, e);
        end
    endtask
    task step(input bit rp);
        logic [3:0] e;
        reg_req_t r;
        framer_events_t v;
        @(posedge clk);
        chk_rdata(rdata, exp_rd[7:0]);
        chk_irq(irq, (st & mk) != 0);
        e = {ev.fcs_err_link1, ev.locked_valid && ev.locked_pos != ev.offline_pos, ev.frame_loss && !fl_old,
            ev.slip_repeat | ev.slip_drop};
        fl_old = ev.frame_loss;
        exp_rd = req.rd && req.addr == ad[4] ? st : req.rd && req.addr == ad[5] ? mk : 0;
        for (int k = 0; k < 4; k++) begin
            if (req.rd && req.addr == ad[k]) begin
                exp_rd = cnt[k];
                cnt[k] = 0;
            end
            if (e[k] && cnt[k] < 'hff) cnt[k]++;
        end
        if (req.wr && req.addr == ad[5]) mk = req.wdata[3:0];
        if (req.wr && req.addr == ad[4]) st = st & ~req.wdata[3:0];
        st = st | e;
        r = req;
        // sticky address so back-to-back reads of one counter are common
        if (cyc % 16 == 0) r.addr = ad[$urandom % 8];
        r.rd = rp && $urandom % 3 == 0;
        r.wr = rp && !r.rd && $urandom % 3 == 0;
        r.wdata = 8'($urandom);
        v = framer_events_t'($urandom);
        // rarer slips, so reads often meet a slip-free cycle
        v.slip_repeat = $urandom % 4 == 0;
        v.slip_drop = $urandom % 4 == 0;
        v.frame_loss = $urandom % 4 ? ev.frame_loss : ~ev.frame_loss;
        v.locked_pos[7:1] = 7'h00;
        v.offline_pos[7:1] = 7'h00;
        req <= r;
        ev <= v;
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            finish_test;
        end
    end
    initial begin
        void'($urandom(32'h4a20));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        // middle test has no reads, so the slip and link 1 checksum counters reach saturation
        for (int t = 0; t < 3; t++) begin
            repeat (t == 1 ? 800 : 1500) step(t != 1);
            $display("test %0d done", t);
        end
        finish_test;
    end
endmodule
bind rx_event_counters rx_event_counters_props u_props (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
    .ev(ev), .irq(irq));
